// File: hdl/psa_defs.vh
// Operation codes, operand selects and reset values for the packed integer datapath
`ifndef PSA_DEFS_VH
`define PSA_DEFS_VH

// ****************************************************************
// Operation set size and operation codes
// ****************************************************************
`define PSA_OP_COUNT        47
`define PSA_OP_ADD_B        6'h00
`define PSA_OP_ADD_W        6'h01
`define PSA_OP_ADD_D        6'h02
`define PSA_OP_SUB_B        6'h03
`define PSA_OP_SUB_W        6'h04
`define PSA_OP_SUB_D        6'h05
`define PSA_OP_ADDS_B       6'h06
`define PSA_OP_ADDS_W       6'h07
`define PSA_OP_SUBS_B       6'h08
`define PSA_OP_SUBS_W       6'h09
`define PSA_OP_ADDUS_B      6'h0A
`define PSA_OP_ADDUS_W      6'h0B
`define PSA_OP_SUBUS_B      6'h0C
`define PSA_OP_SUBUS_W      6'h0D
`define PSA_OP_MUL_HI       6'h0E
`define PSA_OP_MUL_LO       6'h0F
`define PSA_OP_MUL_ADD      6'h10
`define PSA_OP_CEQ_B        6'h11
`define PSA_OP_CEQ_W        6'h12
`define PSA_OP_CEQ_D        6'h13
`define PSA_OP_CGT_B        6'h14
`define PSA_OP_CGT_W        6'h15
`define PSA_OP_CGT_D        6'h16
`define PSA_OP_PACK_SWB     6'h17
`define PSA_OP_PACK_SDW     6'h18
`define PSA_OP_PACK_UWB     6'h19
`define PSA_OP_AND          6'h1A
`define PSA_OP_ANDN         6'h1B
`define PSA_OP_OR           6'h1C
`define PSA_OP_XOR          6'h1D
`define PSA_OP_SHL_W        6'h1E
`define PSA_OP_SHL_D        6'h1F
`define PSA_OP_SHL_Q        6'h20
`define PSA_OP_SHR_W        6'h21
`define PSA_OP_SHR_D        6'h22
`define PSA_OP_SHR_Q        6'h23
`define PSA_OP_SAR_W        6'h24
`define PSA_OP_SAR_D        6'h25
`define PSA_OP_MOVE_D       6'h26
`define PSA_OP_MOVE_Q       6'h27
// Unpack group and state-empty: decoded, handled elsewhere
`define PSA_OP_UNPK_FIRST   6'h28
`define PSA_OP_UNPK_LAST    6'h2D
`define PSA_OP_EMPTY        6'h2E

// ****************************************************************
// Operand source and destination selects
// ****************************************************************
`define PSA_SEL_PACKED      2'h0
`define PSA_SEL_GPR         2'h1
`define PSA_SEL_MEM         2'h2

// ****************************************************************
// Reset values
// ****************************************************************
`define PSA_RST_RESULT      64'h0000000000000000
`define PSA_RST_SEL         2'h0

`endif

// File: hdl/psa_mul_unit.v
// Four signed 16 by 16 word multipliers for the packed datapath
`timescale 1ns/1ps
`default_nettype none

module psa_mul_unit
(
  input  wire [63:0]  a_in,
  input  wire [63:0]  b_in,
  output wire [127:0] prod_out
);

  // ****************************************************************
  // Lane products
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_lane
      wire signed [15:0] a_w = a_in[16*g +: 16];
      wire signed [15:0] b_w = b_in[16*g +: 16];
      // Full 32-bit product, never wider than its lane
      assign prod_out[32*g +: 32] = a_w * b_w;
    end
  endgenerate

endmodule

`default_nettype wire

// File: hdl/psa_alu.v
// Packed integer SIMD execution datapath with one registered result stage
//
// How it works
// - Forty-seven operations exist; unpack and state-empty codes are flagged unsupported here.
// - Wraparound add/sub per byte, word or dword lane, carries dropped.
// - Signed saturating add/sub on byte or word lanes clamp to signed limits.
// - Unsigned saturating add/sub on byte or word lanes clamp to zero or ones.
// - Word multiply gives signed products; high or low sixteen bits kept.
// - Multiply-add sums high and low product pairs into two dwords.
// - Compares test each lane for equality or signed greater-than, dest versus source.
// - Compare lane becomes all ones when true, all zeros otherwise.
// - Compares, like all operations here, never write the status flags.
// - Signed packs narrow words to sbytes or dwords to swords, saturating.
// - Unsigned pack narrows signed words to ubytes: negative zero, large all ones.
// - Doubleword move carries 32 bits between memory, general or packed registers.
// - Quadword move carries 64 bits between memory and packed registers.
// - Signed word saturation gives 7FFF on positive, 8000 on negative overflow.
// - Unsigned byte saturation gives FF on positive, zero on negative overflow.
// - AND, AND-NOT, OR, XOR act on the whole 64-bit quadword.
// - Logical shifts zero-fill; arithmetic right shifts fill with each element's sign.
`timescale 1ns/1ps
`default_nettype none
`include "psa_defs.vh"

module psa_alu
(
  input  wire        core_clk_in,
  input  wire        rst_b_in,
  input  wire        issue_valid_in,
  input  wire [5:0]  op_in,
  input  wire [63:0] dst_in,
  input  wire [1:0]  src_sel_in,
  input  wire [63:0] src_reg_in,
  input  wire [31:0] gpr_in,
  input  wire [63:0] mem_rd_in,
  input  wire [1:0]  dest_sel_in,
  output reg         result_valid_out,
  output reg  [63:0] result_out,
  output reg  [1:0]  dest_sel_out,
  output reg         unsupported_out,
  output reg         flags_we_out
);

  // ****************************************************************
  // Extension and saturation helpers
  // ****************************************************************
  function [32:0] sxb;
    input [7:0] v;
    sxb = {{25{v[7]}}, v};
  endfunction

  function [32:0] zxb;
    input [7:0] v;
    zxb = {25'h0000000, v};
  endfunction

  function [32:0] sxw;
    input [15:0] v;
    sxw = {{17{v[15]}}, v};
  endfunction

  function [32:0] zxw;
    input [15:0] v;
    zxw = {17'h00000, v};
  endfunction

  // Clamp a 33-bit signed value to a signed byte
  function [7:0] sat_sb;
    input signed [32:0] v;
    if (v > 33'sh07F)
      sat_sb = 8'h7F;
    else if (v < -33'sh080)
      sat_sb = 8'h80;
    else
      sat_sb = v[7:0];
  endfunction

  // Clamp a 33-bit signed value to an unsigned byte
  function [7:0] sat_ub;
    input signed [32:0] v;
    if (v > 33'sh0FF)
      sat_ub = 8'hFF;
    else if (v < 33'sh000)
      sat_ub = 8'h00;
    else
      sat_ub = v[7:0];
  endfunction

  // Clamp a 33-bit signed value to a signed word
  function [15:0] sat_sw;
    input signed [32:0] v;
    if (v > 33'sh07FFF)
      sat_sw = 16'h7FFF;
    else if (v < -33'sh08000)
      sat_sw = 16'h8000;
    else
      sat_sw = v[15:0];
  endfunction

  // Clamp a 33-bit signed value to an unsigned word
  function [15:0] sat_uw;
    input signed [32:0] v;
    if (v > 33'sh0FFFF)
      sat_uw = 16'hFFFF;
    else if (v < 33'sh000)
      sat_uw = 16'h0000;
    else
      sat_uw = v[15:0];
  endfunction

  // ****************************************************************
  // Operand selection and multipliers
  // ****************************************************************
  reg  [63:0]  src_op;
  wire [127:0] prod;
  wire [6:0]   cnt;

  // Second operand from packed register, general register or memory
  always @*
  begin
    case (src_sel_in)
      `PSA_SEL_GPR: src_op = {32'h00000000, gpr_in};
      `PSA_SEL_MEM: src_op = mem_rd_in;
      default:      src_op = src_reg_in;
    endcase
  end

  // Counts of 128 and above are pinned to 127 so they never alias to small shifts
  assign cnt = (|src_op[63:7]) ? 7'h7F : src_op[6:0];

  psa_mul_unit u_mul
  (
    .a_in     (dst_in),
    .b_in     (src_op),
    .prod_out (prod)
  );

  // ****************************************************************
  // Lane-parallel arithmetic, compare, pack and shift
  // ****************************************************************
  reg [63:0] add_b, add_w, add_d, sub_b, sub_w, sub_d;
  reg [63:0] adds_b, adds_w, subs_b, subs_w;
  reg [63:0] addus_b, addus_w, subus_b, subus_w;
  reg [63:0] ceq_b, ceq_w, ceq_d, cgt_b, cgt_w, cgt_d;
  reg [63:0] mul_hi, mul_lo, mul_add;
  reg [63:0] pk_swb, pk_sdw, pk_uwb;
  reg [63:0] shl_w, shr_w, sar_w, shl_d, shr_d, sar_d;
  reg [31:0] t32;
  reg [63:0] t64;
  integer    i;

  // Add, subtract, compare and multiply lanes use their own bits only; packs, multiply-add and shift counts cross lanes
  always @*
  begin
    t32 = 32'h00000000;
    t64 = 64'h0000000000000000;
    for (i = 0; i < 8; i = i + 1)
    begin
      add_b[8*i +: 8]   = dst_in[8*i +: 8] + src_op[8*i +: 8];
      sub_b[8*i +: 8]   = dst_in[8*i +: 8] - src_op[8*i +: 8];
      adds_b[8*i +: 8]  = sat_sb(sxb(dst_in[8*i +: 8]) + sxb(src_op[8*i +: 8]));
      subs_b[8*i +: 8]  = sat_sb(sxb(dst_in[8*i +: 8]) - sxb(src_op[8*i +: 8]));
      addus_b[8*i +: 8] = sat_ub(zxb(dst_in[8*i +: 8]) + zxb(src_op[8*i +: 8]));
      subus_b[8*i +: 8] = sat_ub(zxb(dst_in[8*i +: 8]) - zxb(src_op[8*i +: 8]));
      ceq_b[8*i +: 8]   = {8{dst_in[8*i +: 8] == src_op[8*i +: 8]}};
      cgt_b[8*i +: 8]   = {8{$signed(dst_in[8*i +: 8]) > $signed(src_op[8*i +: 8])}};
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      add_w[16*i +: 16]   = dst_in[16*i +: 16] + src_op[16*i +: 16];
      sub_w[16*i +: 16]   = dst_in[16*i +: 16] - src_op[16*i +: 16];
      adds_w[16*i +: 16]  = sat_sw(sxw(dst_in[16*i +: 16]) + sxw(src_op[16*i +: 16]));
      subs_w[16*i +: 16]  = sat_sw(sxw(dst_in[16*i +: 16]) - sxw(src_op[16*i +: 16]));
      addus_w[16*i +: 16] = sat_uw(zxw(dst_in[16*i +: 16]) + zxw(src_op[16*i +: 16]));
      subus_w[16*i +: 16] = sat_uw(zxw(dst_in[16*i +: 16]) - zxw(src_op[16*i +: 16]));
      ceq_w[16*i +: 16]   = {16{dst_in[16*i +: 16] == src_op[16*i +: 16]}};
      cgt_w[16*i +: 16]   = {16{$signed(dst_in[16*i +: 16]) > $signed(src_op[16*i +: 16])}};
      mul_hi[16*i +: 16]  = prod[32*i+16 +: 16];
      mul_lo[16*i +: 16]  = prod[32*i +: 16];
      // Destination words fill the low half, source words the high half
      pk_swb[8*i +: 8]    = sat_sb(sxw(dst_in[16*i +: 16]));
      pk_swb[32+8*i +: 8] = sat_sb(sxw(src_op[16*i +: 16]));
      pk_uwb[8*i +: 8]    = sat_ub(sxw(dst_in[16*i +: 16]));
      pk_uwb[32+8*i +: 8] = sat_ub(sxw(src_op[16*i +: 16]));
      shl_w[16*i +: 16]   = (cnt > 7'h0F) ? 16'h0000 : (dst_in[16*i +: 16] << cnt);
      shr_w[16*i +: 16]   = (cnt > 7'h0F) ? 16'h0000 : (dst_in[16*i +: 16] >> cnt);
      t32 = {{16{dst_in[16*i+15]}}, dst_in[16*i +: 16]} >> ((cnt > 7'h0F) ? 7'h10 : cnt);
      sar_w[16*i +: 16]   = t32[15:0];
    end
    for (i = 0; i < 2; i = i + 1)
    begin
      add_d[32*i +: 32]   = dst_in[32*i +: 32] + src_op[32*i +: 32];
      sub_d[32*i +: 32]   = dst_in[32*i +: 32] - src_op[32*i +: 32];
      ceq_d[32*i +: 32]   = {32{dst_in[32*i +: 32] == src_op[32*i +: 32]}};
      cgt_d[32*i +: 32]   = {32{$signed(dst_in[32*i +: 32]) > $signed(src_op[32*i +: 32])}};
      // Only 8000*8000 twice overflows; it wraps like the hardware sum
      mul_add[32*i +: 32] = prod[64*i +: 32] + prod[64*i+32 +: 32];
      pk_sdw[16*i +: 16]  = sat_sw(dst_in[32*i+31] ? {1'b1, dst_in[32*i +: 32]} : {1'b0, dst_in[32*i +: 32]});
      pk_sdw[32+16*i +: 16] = sat_sw(src_op[32*i+31] ? {1'b1, src_op[32*i +: 32]} : {1'b0, src_op[32*i +: 32]});
      shl_d[32*i +: 32]   = (cnt > 7'h1F) ? 32'h00000000 : (dst_in[32*i +: 32] << cnt);
      shr_d[32*i +: 32]   = (cnt > 7'h1F) ? 32'h00000000 : (dst_in[32*i +: 32] >> cnt);
      t64 = {{32{dst_in[32*i+31]}}, dst_in[32*i +: 32]} >> ((cnt > 7'h1F) ? 7'h20 : cnt);
      sar_d[32*i +: 32]   = t64[31:0];
    end
  end

  // ****************************************************************
  // Result selection
  // ****************************************************************
  reg [63:0] result_next;
  reg        unsupported_next;

  always @*
  begin
    unsupported_next = 1'b0;
    case (op_in)
      `PSA_OP_ADD_B:    result_next = add_b;
      `PSA_OP_ADD_W:    result_next = add_w;
      `PSA_OP_ADD_D:    result_next = add_d;
      `PSA_OP_SUB_B:    result_next = sub_b;
      `PSA_OP_SUB_W:    result_next = sub_w;
      `PSA_OP_SUB_D:    result_next = sub_d;
      `PSA_OP_ADDS_B:   result_next = adds_b;
      `PSA_OP_ADDS_W:   result_next = adds_w;
      `PSA_OP_SUBS_B:   result_next = subs_b;
      `PSA_OP_SUBS_W:   result_next = subs_w;
      `PSA_OP_ADDUS_B:  result_next = addus_b;
      `PSA_OP_ADDUS_W:  result_next = addus_w;
      `PSA_OP_SUBUS_B:  result_next = subus_b;
      `PSA_OP_SUBUS_W:  result_next = subus_w;
      `PSA_OP_MUL_HI:   result_next = mul_hi;
      `PSA_OP_MUL_LO:   result_next = mul_lo;
      `PSA_OP_MUL_ADD:  result_next = mul_add;
      `PSA_OP_CEQ_B:    result_next = ceq_b;
      `PSA_OP_CEQ_W:    result_next = ceq_w;
      `PSA_OP_CEQ_D:    result_next = ceq_d;
      `PSA_OP_CGT_B:    result_next = cgt_b;
      `PSA_OP_CGT_W:    result_next = cgt_w;
      `PSA_OP_CGT_D:    result_next = cgt_d;
      `PSA_OP_PACK_SWB: result_next = pk_swb;
      `PSA_OP_PACK_SDW: result_next = pk_sdw;
      `PSA_OP_PACK_UWB: result_next = pk_uwb;
      `PSA_OP_AND:      result_next = dst_in & src_op;
      `PSA_OP_ANDN:     result_next = ~dst_in & src_op;
      `PSA_OP_OR:       result_next = dst_in | src_op;
      `PSA_OP_XOR:      result_next = dst_in ^ src_op;
      `PSA_OP_SHL_W:    result_next = shl_w;
      `PSA_OP_SHL_D:    result_next = shl_d;
      `PSA_OP_SHL_Q:    result_next = (cnt > 7'h3F) ? 64'h0000000000000000 : (dst_in << cnt);
      `PSA_OP_SHR_W:    result_next = shr_w;
      `PSA_OP_SHR_D:    result_next = shr_d;
      `PSA_OP_SHR_Q:    result_next = (cnt > 7'h3F) ? 64'h0000000000000000 : (dst_in >> cnt);
      `PSA_OP_SAR_W:    result_next = sar_w;
      `PSA_OP_SAR_D:    result_next = sar_d;
      // Low 32 bits move; a packed destination gets its upper half cleared
      `PSA_OP_MOVE_D:   result_next = {32'h00000000, src_op[31:0]};
      `PSA_OP_MOVE_Q:   result_next = src_op;
      default:
      begin
        // Unpack, state-empty and unused codes yield zero and a flag
        result_next      = `PSA_RST_RESULT;
        unsupported_next = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // Result register
  // ****************************************************************
  // One stage only; status flags are never written by this unit
  always @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      result_valid_out <= 1'b0;
      result_out       <= `PSA_RST_RESULT;
      dest_sel_out     <= `PSA_RST_SEL;
      unsupported_out  <= 1'b0;
      flags_we_out     <= 1'b0;
    end
    else
    begin
      result_valid_out <= issue_valid_in;
      result_out       <= issue_valid_in ? result_next : result_out;
      dest_sel_out     <= issue_valid_in ? dest_sel_in : dest_sel_out;
      unsupported_out  <= issue_valid_in & unsupported_next;
      flags_we_out     <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: test/psa_alu_monitor.sv
// Port checker for the packed integer datapath
`timescale 1ns/1ps
`default_nettype none
`include "psa_defs.vh"
module psa_alu_monitor
(
  input wire logic        core_clk_in,
  input wire logic        rst_b_in,
  input wire logic        issue_valid_in,
  input wire logic [5:0]  op_in,
  input wire logic [63:0] dst_in,
  input wire logic [1:0]  src_sel_in,
  input wire logic [63:0] src_reg_in,
  input wire logic [31:0] gpr_in,
  input wire logic [63:0] mem_rd_in,
  input wire logic [1:0]  dest_sel_in,
  input wire logic        result_valid_out,
  input wire logic [63:0] result_out,
  input wire logic [1:0]  dest_sel_out,
  input wire logic        unsupported_out,
  input wire logic        flags_we_out
);
  // Lane helpers, so that $past only ever sees plain signals
  logic [31:0] hi_diff;
  logic        pk;
  assign hi_diff = dst_in[63:32] ^ src_reg_in[63:32];
  assign pk      = issue_valid_in && src_sel_in == `PSA_SEL_PACKED;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  // ****************************************************************
  // Checks
  // ****************************************************************
  a_valid_follows: assert property (issue_valid_in |=> result_valid_out)
    else $error("no result pulse after issue");
  a_idle_holds: assert property (!issue_valid_in |=> !result_valid_out && $stable(result_out) && $stable(dest_sel_out))
    else $error("outputs moved without issue");
  a_dest_carried: assert property (issue_valid_in |=> dest_sel_out == $past(dest_sel_in))
    else $error("destination select not carried");
  a_flags_untouched: assert property (flags_we_out == 1'b0)
    else $error("status flags written");
  a_unsup_flagged: assert property (issue_valid_in && op_in > 6'h27 |=> unsupported_out && result_out == 64'h0)
    else $error("unimplemented code not flagged");
  a_eq_mask_hi: assert property (pk && op_in == `PSA_OP_CEQ_D |=>
    result_out[63:32] == (($past(hi_diff) == 32'h0) ? 32'hFFFFFFFF : 32'h0)) else $error("dword equal mask wrong");
  a_sat_word_top: assert property (pk && op_in == `PSA_OP_ADDS_W && dst_in[15:0] == 16'h7FFF && !src_reg_in[15]
    |=> result_out[15:0] == 16'h7FFF) else $error("word saturation wrong");
  a_xor_quad: assert property (pk && op_in == `PSA_OP_XOR |=> result_out == ($past(dst_in) ^ $past(src_reg_in)))
    else $error("quadword xor wrong");
  // Main scenarios reached
  c_unsup: cover property (issue_valid_in && op_in > 6'h27);
  c_back_to_back: cover property (result_valid_out ##1 result_valid_out);
  c_move_mem: cover property (issue_valid_in && op_in == `PSA_OP_MOVE_Q && src_sel_in == `PSA_SEL_MEM);
endmodule
bind psa_alu psa_alu_monitor mon_u
(
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .issue_valid_in(issue_valid_in), .op_in(op_in),
  .dst_in(dst_in), .src_sel_in(src_sel_in), .src_reg_in(src_reg_in), .gpr_in(gpr_in), .mem_rd_in(mem_rd_in),
  .dest_sel_in(dest_sel_in), .result_valid_out(result_valid_out), .result_out(result_out),
  .dest_sel_out(dest_sel_out), .unsupported_out(unsupported_out), .flags_we_out(flags_we_out)
);
`default_nettype wire

// File: test/psa_issue_model.sv
// Issue side model: presents one packed operation per cycle to the datapath
`timescale 1ns/1ps
`default_nettype none
module psa_issue_model
(
  input  wire logic        clk_in,
  output var  logic        valid_out,
  output var  logic [5:0]  op_out,
  output var  logic [63:0] dst_out,
  output var  logic [1:0]  sel_out,
  output var  logic [63:0] src_out,
  output var  logic [31:0] gpr_out,
  output var  logic [63:0] mem_out,
  output var  logic [1:0]  dsel_out
);
  // Quiet at time zero
  initial
  begin
    {valid_out, op_out, dst_out, sel_out, src_out, gpr_out, mem_out, dsel_out} = '0;
  end
  // Presented after a falling edge, taken at the next rising edge
  task automatic drive(input logic [5:0] op, input logic [63:0] dst, input logic [1:0] sel,
                       input logic [63:0] src, input logic [31:0] gpr, input logic [63:0] mem, input logic [1:0] dsel);
    @(negedge clk_in);
    {valid_out, op_out, dst_out, sel_out, src_out, gpr_out, mem_out, dsel_out} = {1'b1, op, dst, sel, src, gpr, mem, dsel};
  endtask
  // Operands are inverted when released, so a stale value never passes for a fresh one
  task automatic idle;
    @(negedge clk_in);
    valid_out = 1'b0;
    {op_out, dst_out, src_out, gpr_out, mem_out} = ~{op_out, dst_out, src_out, gpr_out, mem_out};
  endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the packed integer datapath
`timescale 1ns/1ps
`default_nettype none
`include "psa_defs.vh"
module testbench;
  logic        core_clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  wire logic   issue_valid_in;
  wire logic [5:0]  op_in;
  wire logic [63:0] dst_in, src_reg_in, mem_rd_in;
  wire logic [1:0]  src_sel_in, dest_sel_in;
  wire logic [31:0] gpr_in;
  logic        result_valid_out, unsupported_out, flags_we_out;
  logic [63:0] result_out, rd, rsrc, rmem;
  logic [1:0]  dest_sel_out;
  logic [31:0] rg, rs = 32'h8F31B7A1;
  int          err_total, n_compared, cyc;
  typedef struct packed {logic [63:0] res; logic [1:0] dsel; logic unsup;} psa_exp_t;
  psa_exp_t    expq[$];
  psa_exp_t    got;
  logic [133:0] dir[11] = '{
    {`PSA_OP_ADDS_W,  64'h7FFF800000017FFF, 64'h0001FFFF00010001},
    {`PSA_OP_ADDUS_B, 64'hFF00FF800102FEFF, 64'h01000180FFFF0101},
    {`PSA_OP_SUBUS_B, 64'h0000000000000001, 64'h0101010101010102},
    {`PSA_OP_SUBS_B,  64'h7F807F8000000000, 64'hFF01FF7F00000000},
    {`PSA_OP_SUBUS_W, 64'hFFFF000000010005, 64'h0001000100020003},
    {`PSA_OP_ADD_B,   64'hFFFFFFFFFFFFFFFF, 64'h0101010101010101},
    {`PSA_OP_MUL_ADD, 64'h8000800080008000, 64'h8000800080008000},
    {`PSA_OP_PACK_UWB, 64'h8000010000FFFFFF, 64'h00807FFF00000001},
    {`PSA_OP_PACK_SDW, 64'h8000000000008000, 64'h7FFFFFFFFFFF7FFF},
    {`PSA_OP_CEQ_D,   64'h1234567800000000, 64'h1234567800000001},
    {`PSA_OP_SAR_W,   64'h80007FFF80010001, 64'h0000000000000010}};
  always #25 core_clk_in = ~core_clk_in;
  psa_issue_model mdl_u (.clk_in(core_clk_in), .valid_out(issue_valid_in), .op_out(op_in), .dst_out(dst_in),
    .sel_out(src_sel_in), .src_out(src_reg_in), .gpr_out(gpr_in), .mem_out(mem_rd_in), .dsel_out(dest_sel_in));
  psa_alu dut_u (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .issue_valid_in(issue_valid_in), .op_in(op_in),
    .dst_in(dst_in), .src_sel_in(src_sel_in), .src_reg_in(src_reg_in), .gpr_in(gpr_in), .mem_rd_in(mem_rd_in),
    .dest_sel_in(dest_sel_in), .result_valid_out(result_valid_out), .result_out(result_out),
    .dest_sel_out(dest_sel_out), .unsupported_out(unsupported_out), .flags_we_out(flags_we_out));
  // ****************************************************************
  // Reference model and helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic longint clp(input longint v, input longint lo, input longint hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  // Lane by lane result; a is the destination operand, b the selected second operand
  function automatic logic [63:0] psa_ref(input logic [5:0] op, input logic [63:0] a, input logic [63:0] b);
    int w, n;
    logic [63:0] m, ua, ub, r, res;
    longint sa, sb, mn, mx, lo, hi, pr[4];
    if (op == `PSA_OP_MOVE_D) return {32'h0, b[31:0]};
    if (op == `PSA_OP_MOVE_Q) return b;
    if (op > 6'h27) return 64'h0;
    if (op < 6) w = 8 << (op % 3);
    else if (op < 14) w = op[0] ? 16 : 8;
    else if (op < 17) w = 16;
    else if (op < 23) w = 8 << ((op - 17) % 3);
    else if (op < 30) w = (op == 24) ? 32 : ((op < 26) ? 16 : 64);
    else w = 16 << ((op - 30) % 3);
    n = 64 / w;
    m = (w == 64) ? '1 : (64'h1 << w) - 64'h1;
    mx = (longint'(1) <<< (w - 1)) - 1;
    mn = -mx - 1;
    lo = (op == `PSA_OP_PACK_UWB) ? 0 : -(longint'(1) <<< (w / 2 - 1));
    hi = (op == `PSA_OP_PACK_UWB) ? (longint'(1) <<< (w / 2)) - 1 : (longint'(1) <<< (w / 2 - 1)) - 1;
    res = 64'h0;
    for (int i = 0; i < n; i++)
    begin
      ua = (a >> (i * w)) & m;
      ub = (b >> (i * w)) & m;
      sa = (w < 64 && ua[w - 1]) ? longint'(ua) - (longint'(1) <<< w) : longint'(ua);
      sb = (w < 64 && ub[w - 1]) ? longint'(ub) - (longint'(1) <<< w) : longint'(ub);
      pr[i % 4] = sa * sb;
      case (op) inside
        [6'h00:6'h02]: r = ua + ub;
        [6'h03:6'h05]: r = ua - ub;
        [6'h06:6'h07]: r = clp(sa + sb, mn, mx);
        [6'h08:6'h09]: r = clp(sa - sb, mn, mx);
        [6'h0A:6'h0B]: r = (ua + ub > m) ? m : ua + ub;
        [6'h0C:6'h0D]: r = (ub > ua) ? 64'h0 : ua - ub;
        6'h0E: r = 64'(pr[i % 4] >>> 16);
        6'h0F: r = 64'(pr[i % 4]);
        [6'h11:6'h13]: r = (ua == ub) ? m : 64'h0;
        [6'h14:6'h16]: r = (sa > sb) ? m : 64'h0;
        [6'h17:6'h19]: res = res | ((64'(clp(sa, lo, hi)) & (m >> w / 2)) << (i * w / 2))
                                 | ((64'(clp(sb, lo, hi)) & (m >> w / 2)) << ((i + n) * w / 2));
        6'h1A: r = ua & ub;
        6'h1B: r = ~ua & ub;
        6'h1C: r = ua | ub;
        6'h1D: r = ua ^ ub;
        [6'h1E:6'h20]: r = (b >= w) ? 64'h0 : ua << b;
        [6'h21:6'h23]: r = (b >= w) ? 64'h0 : ua >> b;
        default: r = (b >= w) ? ((sa < 0) ? m : 64'h0) : 64'(sa >>> b);
      endcase
      if (op < 6'h17 || op > 6'h19) res = res | ((r & m) << (i * w));
    end
    if (op == `PSA_OP_MUL_ADD) res = {32'(pr[3] + pr[2]), 32'(pr[1] + pr[0])};
    return res;
  endfunction
  task automatic mis(input string msg);
    err_total++;
    $display("[ERR] %0t %s", $time, msg);
  endtask
  task automatic conclude;
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Notes the expectation, then hands the operation to the issue model
  task automatic send(input logic [5:0] op, input logic [63:0] dst, input logic [1:0] sel,
                      input logic [63:0] src, input logic [31:0] gpr, input logic [63:0] mem);
    logic [1:0]  dsel;
    logic [63:0] b;
    dsel = 2'(rnd() % 3);
    b = (sel == `PSA_SEL_GPR) ? {32'h0, gpr} : ((sel == `PSA_SEL_MEM) ? mem : src);
    expq.push_back({psa_ref(op, dst, b), dsel, op > 6'h27});
    mdl_u.drive(op, dst, sel, src, gpr, mem, dsel);
  endtask
  // Each result pulse retires the oldest expectation
  always @(negedge core_clk_in)
  begin
    if (rst_b_in === 1'b1 && result_valid_out === 1'b1)
    begin
      n_compared++;
      got = expq.size() ? expq.pop_front() : 'x;
      if ({result_out, dest_sel_out, unsupported_out} !== got) mis($sformatf("got %h want %h", result_out, got.res));
    end
    if (rst_b_in === 1'b1 && flags_we_out !== 1'b0) mis("status flags written");
  end
  // Hang guard, well above the few hundred cycles of the run
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      mis("timeout");
      conclude();
    end
  end
  // Reset, boundary table, then every code with every operand source
  initial
  begin
    repeat (3) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rst_b_in = 1'b1;
    n_compared++;
    if ({result_valid_out, result_out, dest_sel_out, unsupported_out, flags_we_out} !== 69'h0) mis("reset values");
    foreach (dir[i]) send(dir[i][133:128], dir[i][127:64], `PSA_SEL_PACKED, dir[i][63:0], 32'h0, 64'h0);
    for (int k = 0; k < 256; k++)
    begin
      rd = {rnd(), rnd()};
      rsrc = {rnd(), rnd()};
      rg = rnd();
      rmem = {rnd(), rnd()};
      if (k[5:0] >= 6'h1E && k[5:0] <= 6'h25) {rsrc, rg, rmem} = {64'(rnd() % 70), 32'(rnd() % 70), 64'(rnd() % 70)};
      if (rnd() % 8 == 0) mdl_u.idle();
      send(k[5:0], rd, k[7:6], rsrc, rg, rmem);
    end
    mdl_u.idle();
    repeat (3) @(negedge core_clk_in);
    n_compared++;
    if (expq.size() != 0) mis("results missing");
    conclude();
  end
endmodule
`default_nettype wire
